// >>> src/cfg_readout.sv
// Purpose: read-out side of a serial configuration memory feeding an FPGA
// Assumes: pins from the FPGA are asynchronous; array read port is same-clock
// Notes: array contents and the two-wire programming engine live outside
`timescale 1ns/1ns
module cfg_readout #(
  parameter int unsigned DENSITY_BITS = cfg_readout_pkg::DENSITY_MAX
) (
  input  wire logic                               i_clock,
  input  wire logic                               i_sys_rst,
  input  wire logic                               i_configuration_clock,
  input  wire logic                               i_chip_select_n,
  input  wire logic                               i_reset_oe,
  input  wire logic                               i_program_mode_select_n,
  input  wire logic                               i_block_protect,
  input  wire logic                               i_device_select_bit,
  input  wire cfg_readout_pkg::polarity_bytes_t   i_polarity_bytes,
  input  wire logic                               i_read_bit,
  input  wire logic                               i_prog_wr_req,
  input  wire logic [cfg_readout_pkg::ADDR_W-1:0] i_prog_wr_addr,
  output logic      [cfg_readout_pkg::ADDR_W-1:0] o_read_addr,
  output logic                                    o_data,
  output logic                                    o_data_oe,
  output logic                                    o_cascade_select_out_n,
  output logic                                    o_prog_wr_en,
  output logic      [cfg_readout_pkg::ADDR_W-1:0] o_prog_wr_addr,
  output logic                                    o_prog_wr_refused
);

  localparam int unsigned LAST_INDEX = DENSITY_BITS - 1;
  localparam logic [cfg_readout_pkg::ADDR_W-1:0] LAST_ADDR =
    LAST_INDEX[cfg_readout_pkg::ADDR_W-1:0];
  localparam bit HAS_CASCADE = (DENSITY_BITS > cfg_readout_pkg::DENSITY_MIN);

  cfg_readout_pkg::pins_t      pins_raw;
  cfg_readout_pkg::pins_t      pins_s;
  cfg_readout_pkg::read_state_t state_q;
  cfg_readout_pkg::read_state_t state_d;
  logic [cfg_readout_pkg::ADDR_W-1:0] addr_q;
  logic [cfg_readout_pkg::ADDR_W-1:0] addr_d;
  logic                               cfg_prev_q;
  logic                               cfg_rise;
  logic                               invert_q;
  logic                               polarity_loaded_q;
  logic                               reset_lvl;
  logic                               prog_mode;
  logic                               enabled;
  logic                               at_last;
  logic                               wr_allowed;

  function automatic logic bytes_all_match(input cfg_readout_pkg::polarity_bytes_t b);
    bytes_all_match = (b.byte0 == cfg_readout_pkg::POLARITY_INVERT_CODE) &&
                      (b.byte1 == cfg_readout_pkg::POLARITY_INVERT_CODE) &&
                      (b.byte2 == cfg_readout_pkg::POLARITY_INVERT_CODE) &&
                      (b.byte3 == cfg_readout_pkg::POLARITY_INVERT_CODE);
  endfunction

  function automatic logic in_protected_block(input logic [cfg_readout_pkg::ADDR_W-1:0] a);
    in_protected_block = (a < cfg_readout_pkg::PROTECT_BLOCK_END);
  endfunction

  assign pins_raw.config_clock          = i_configuration_clock; // R10
  assign pins_raw.chip_select_n         = i_chip_select_n;
  assign pins_raw.reset_oe              = i_reset_oe;
  assign pins_raw.program_mode_select_n = i_program_mode_select_n;
  assign pins_raw.block_protect         = i_block_protect;
  assign pins_raw.device_select_bit     = i_device_select_bit;

  pin_sync #(
    .WIDTH (cfg_readout_pkg::PIN_COUNT)
  ) u_pin_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (pins_raw),
    .o_sync    (pins_s)
  );

  // polarity bytes caught once after power-up release
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      invert_q          <= 1'b0;
      polarity_loaded_q <= 1'b0;
    end else if (!polarity_loaded_q) begin
      invert_q          <= bytes_all_match(i_polarity_bytes); // R07
      polarity_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_prev_q <= 1'b0;
    end else begin
      cfg_prev_q <= pins_s.config_clock;
    end
  end

  assign cfg_rise  = pins_s.config_clock && !cfg_prev_q;
  assign reset_lvl = invert_q ? !pins_s.reset_oe : pins_s.reset_oe; // R07
  assign prog_mode = !pins_s.program_mode_select_n; // R13
  assign enabled   = !prog_mode && !reset_lvl && !pins_s.chip_select_n &&
                     (state_q == cfg_readout_pkg::READ_ON); // R02 R03 R05 R13
  assign at_last   = (addr_q == LAST_ADDR); // R08

  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    if (reset_lvl && !prog_mode) begin
      state_d = cfg_readout_pkg::READ_ON; // R04
      addr_d  = cfg_readout_pkg::ADDR_ZERO; // R01 R04
    end else if (enabled && cfg_rise) begin
      case (state_q)
        cfg_readout_pkg::READ_ON: begin
          if (at_last) begin
            state_d = cfg_readout_pkg::EXHAUSTED; // R05
          end else begin
            addr_d = addr_q + cfg_readout_pkg::ADDR_ONE; // R11 R15
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= cfg_readout_pkg::READ_ON;
      addr_q  <= cfg_readout_pkg::ADDR_ZERO; // R06
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
    end
  end

  // data pin driver
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read_addr <= cfg_readout_pkg::ADDR_ZERO;
      o_data      <= 1'b0;
      o_data_oe   <= 1'b0;
    end else begin
      o_read_addr <= addr_d;
      o_data      <= i_read_bit; // R15
      o_data_oe   <= enabled && (state_d == cfg_readout_pkg::READ_ON); // R01 R02 R03 R05
    end
  end

  generate
    if (HAS_CASCADE) begin : g_cascade
      always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_cascade_select_out_n <= 1'b1;
        end else if (reset_lvl || prog_mode) begin
          o_cascade_select_out_n <= 1'b1; // R12
        end else if (state_d == cfg_readout_pkg::EXHAUSTED) begin
          o_cascade_select_out_n <= pins_s.chip_select_n; // R12
        end else begin
          o_cascade_select_out_n <= 1'b1;
        end
      end
    end else begin : g_no_cascade
      always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_cascade_select_out_n <= 1'b1;
        end else begin
          o_cascade_select_out_n <= 1'b1; // R09
        end
      end
    end
  endgenerate

  // write gate for the programming engine
  assign wr_allowed = !(pins_s.block_protect && in_protected_block(i_prog_wr_addr)); // R14

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prog_wr_en      <= 1'b0;
      o_prog_wr_addr    <= cfg_readout_pkg::ADDR_ZERO;
      o_prog_wr_refused <= 1'b0;
    end else begin
      o_prog_wr_addr    <= i_prog_wr_addr;
      o_prog_wr_en      <= i_prog_wr_req && prog_mode &&
                           pins_s.device_select_bit && wr_allowed; // R13 R14
      o_prog_wr_refused <= i_prog_wr_req && prog_mode &&
                           pins_s.device_select_bit && !wr_allowed; // R14
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  property p_reset_clears;
    (reset_lvl && !prog_mode) |=> (!o_data_oe && addr_q == cfg_readout_pkg::ADDR_ZERO);
  endproperty
  a_reset_clears: assert property (p_reset_clears) // R01
    else $error("reset level did not clear counter or float data");

  property p_cs_high_floats;
    (pins_s.chip_select_n && !reset_lvl) |=> (!o_data_oe && $stable(addr_q));
  endproperty
  a_cs_high_floats: assert property (p_cs_high_floats) // R02
    else $error("chip select high did not halt and float");

  property p_enable_drives;
    (enabled && !(cfg_rise && at_last)) |=> o_data_oe;
  endproperty
  a_enable_drives: assert property (p_enable_drives) // R03
    else $error("enabled device did not drive data");

  property p_reset_any_cs;
    $rose(reset_lvl) && !prog_mode |=> !o_data_oe ##1 !o_data_oe;
  endproperty
  a_reset_any_cs: assert property (p_reset_any_cs) // R04
    else $error("renewed reset did not float data");

  property p_done_floats;
    (state_q == cfg_readout_pkg::EXHAUSTED) |-> !o_data_oe;
  endproperty
  a_done_floats: assert property (p_done_floats) // R05
    else $error("data driven after last bit");

  property p_advance;
    (enabled && cfg_rise && !at_last) |=> (addr_q == $past(addr_q) + cfg_readout_pkg::ADDR_ONE);
  endproperty
  a_advance: assert property (p_advance) // R11
    else $error("counter did not advance on clock edge");

  property p_cascade_low;
    (HAS_CASCADE && state_d == cfg_readout_pkg::EXHAUSTED && !pins_s.chip_select_n &&
     !reset_lvl && !prog_mode) |=> !o_cascade_select_out_n;
  endproperty
  a_cascade_low: assert property (p_cascade_low) // R12
    else $error("cascade output not low after last bit");

  property p_cascade_high_after_reset;
    (reset_lvl && !prog_mode) |=> o_cascade_select_out_n;
  endproperty
  a_cascade_high_after_reset: assert property (p_cascade_high_after_reset) // R12
    else $error("cascade output low after reset");

  property p_prog_ignores_cs;
    prog_mode |=> (!o_data_oe && $stable(addr_q));
  endproperty
  a_prog_ignores_cs: assert property (p_prog_ignores_cs) // R13
    else $error("read-out active in program mode");

  property p_protect;
    o_prog_wr_en |-> (!$past(pins_s.block_protect) || !in_protected_block(o_prog_wr_addr));
  endproperty
  a_protect: assert property (p_protect) // R14
    else $error("write granted into protected block");

endmodule

// >>> src/cfg_readout_pkg.sv
// Purpose: shared constants and carriers for the serial configuration read-out block
// Assumes: one system clock, all pins asynchronous to it
// Notes: array contents sit outside this block behind a one-bit read port
//
// Operation
// R01 - reset level clears the address counter and floats the data output
// R02 - chip select High after reset keeps counter halted, data output floating
// R03 - enable level with chip select Low enables counter and data driver
// R04 - renewed reset level clears counter and floats data regardless of chip select
// R05 - after the last bit and cascade output Low, data output floats
// R06 - power-up reset clears the address counter without any pin action
// R07 - four nonvolatile bytes select which level of the reset input resets
// R08 - one-bit-wide array, density 65,536 to 4,194,304 bits, read serially
// R09 - smallest density has no cascade output; it stays High
// R10 - the FPGA drives chip select, reset/enable and configuration clock directly
// R11 - each clock edge while selected and enabled advances the counters
// R12 - cascade output Low at end, follows chip select until reset, then High
// R13 - program mode select Low enters programming; chip select then ignored
// R14 - block protect High refuses writes to the lowest block; Low allows all
// R15 - enabled data output shows current bit, next bit on each rising clock
package cfg_readout_pkg;

  localparam int unsigned ADDR_W           = 22;
  localparam int unsigned DENSITY_MIN      = 65536;
  localparam int unsigned DENSITY_MAX      = 4194304;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 22'h00_0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 22'h00_0001;
  localparam logic [ADDR_W-1:0] PROTECT_BLOCK_END = 22'h00_2000;
  localparam logic [7:0] POLARITY_INVERT_CODE = 8'h00;
  localparam int unsigned POLARITY_BYTES   = 4;
  localparam int unsigned PIN_COUNT        = 6;

  typedef struct packed {
    logic config_clock;
    logic chip_select_n;
    logic reset_oe;
    logic program_mode_select_n;
    logic block_protect;
    logic device_select_bit;
  } pins_t;

  typedef struct packed {
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] byte1;
    logic [7:0] byte0;
  } polarity_bytes_t;

  typedef enum logic {
    READ_ON,
    EXHAUSTED
  } read_state_t;

endpackage

// >>> src/pin_sync.sv
// Purpose: two-stage synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1_q <= '0;
      o_sync   <= '0;
    end else begin
      stage1_q <= i_async;
      o_sync   <= stage1_q;
    end
  end

endmodule

// >>> dv/fpga_master_model.sv
// Purpose: far-side FPGA model driving the configuration pins in master serial mode
// Assumes: pins change just after a falling system clock edge
// Notes: configuration clock rests low between bits
`timescale 1ns/1ns
module fpga_master_model (
  input  wire logic i_clock,
  output logic      o_configuration_clock,
  output logic      o_chip_select_n,
  output logic      o_reset_oe
);
  initial begin
    o_configuration_clock = 1'b0;
    o_chip_select_n       = 1'b1;
    o_reset_oe            = 1'b1;
  end

  task automatic set_pins(input logic cs_n, input logic rst_oe);
    @(negedge i_clock);
    o_chip_select_n = cs_n;
    o_reset_oe      = rst_oe;
  endtask

  // phases in system clock periods, 1 at least or the edge is lost
  task automatic clock_bit(input int hi, input int lo);
    @(negedge i_clock);
    o_configuration_clock = 1'b1;
    repeat (hi) @(negedge i_clock);
    o_configuration_clock = 1'b0;
    repeat (lo) @(negedge i_clock);
  endtask
endmodule

// >>> dv/serial_config_memory_readout_tb.sv
// Purpose: self-checking bench for the configuration read-out block
// Assumes: smallest density, so no cascade output and short address range
// Notes: array modelled as 256 random bits repeating over the address space
`timescale 1ns/1ns
module serial_config_memory_readout_tb;
  logic                             i_clock = 1'b0;
  logic                             i_sys_rst = 1'b1;
  logic                             pm_n = 1'b1;
  logic                             bp = 1'b0;
  logic                             dsel = 1'b0;
  logic                             wr_req = 1'b0;
  logic [21:0]                      wr_addr = 22'h00_0000;
  cfg_readout_pkg::polarity_bytes_t pol;
  logic [255:0]                     mem;
  wire logic                        cfg_clk, cs_n, rst_oe;
  logic [21:0]                      rd_addr, wr_addr_q;
  logic                             dout, doe, cascade_n, wr_en, wr_ref, exp_oe, exp_en;
  logic                             rst_lvl = 1'b1;
  int                               n_fail, comparisons, exp_addr;

  always #4 i_clock = ~i_clock;

  fpga_master_model fpga_master_model_i (.i_clock(i_clock), .o_configuration_clock(cfg_clk),
    .o_chip_select_n(cs_n), .o_reset_oe(rst_oe));

  cfg_readout #(.DENSITY_BITS(65536)) cfg_readout_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_configuration_clock(cfg_clk), .i_chip_select_n(cs_n), .i_reset_oe(rst_oe),
    .i_program_mode_select_n(pm_n), .i_block_protect(bp), .i_device_select_bit(dsel),
    .i_polarity_bytes(pol), .i_read_bit(mem[rd_addr[7:0]]), .i_prog_wr_req(wr_req),
    .i_prog_wr_addr(wr_addr), .o_read_addr(rd_addr), .o_data(dout), .o_data_oe(doe),
    .o_cascade_select_out_n(cascade_n), .o_prog_wr_en(wr_en), .o_prog_wr_addr(wr_addr_q),
    .o_prog_wr_refused(wr_ref));

  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (5) @(negedge i_clock);
  endtask

  task automatic check_read();
    check(22'(doe), 22'(exp_oe));
    check(rd_addr, 22'(exp_addr));
    if (exp_oe) check(22'(dout), 22'(mem[exp_addr % 256]));
    check(22'(cascade_n), 22'h00_0001);
  endtask

  task automatic pins(input logic c, input logic r, input logic en, input logic oe);
    fpga_master_model_i.set_pins(c, r);
    settle();
    exp_en = en;
    exp_oe = oe;
    if (r == rst_lvl) exp_addr = 0;
    check_read();
  endtask

  task automatic read_bits(input int n);
    for (int i = 0; i < n; i++) begin
      fpga_master_model_i.clock_bit(3 + $urandom % 4, 3 + $urandom % 4);
      if (exp_en) exp_addr++;
      check_read();
    end
  endtask

  task automatic write_req(input logic [21:0] a, input logic grant, input logic refuse);
    wr_req = 1'b1;
    wr_addr = a;
    @(negedge i_clock);
    check(22'(wr_en), 22'(grant));
    check(22'(wr_ref), 22'(refuse));
    if (grant) check(wr_addr_q, a);
  endtask

  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (12) @(negedge i_clock);
    i_sys_rst = 1'b0;
    exp_addr = 0;
    settle();
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    logic [21:0] a;
    void'($urandom(63476));
    for (int i = 0; i < 8; i++) mem[i*32 +: 32] = $urandom;
    pol = $urandom | 32'h0000_0001;
    exp_addr = 0;
    do_reset();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    read_bits(3);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    read_bits(20 + $urandom % 40);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    read_bits(2);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    read_bits(5);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    read_bits(3);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pm_n = 1'b0;
    dsel = 1'b1;
    for (int p = 0; p < 2; p++) begin
      bp = p[0];
      settle();
      for (int k = 0; k < 12; k++) begin
        a = ($urandom % 2) ? 22'($urandom % 32'h0000_2000) : 22'($urandom);
        write_req(a, !(bp && a < cfg_readout_pkg::PROTECT_BLOCK_END),
          bp && a < cfg_readout_pkg::PROTECT_BLOCK_END);
      end
    end
    write_req(22'h00_1fff, 1'b0, 1'b1);
    write_req(22'h00_2000, 1'b1, 1'b0);
    wr_req = 1'b0;
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    dsel = 1'b0;
    settle();
    write_req(22'h00_3000, 1'b0, 1'b0);
    dsel = 1'b1;
    pm_n = 1'b1;
    settle();
    write_req(22'h00_3000, 1'b0, 1'b0);
    wr_req = 1'b0;
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pol = 32'h0000_0000;
    rst_lvl = 1'b0;
    do_reset();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    read_bits(6);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
